// ==== hdl/coa_core.sv ====
// Operand addressing core: core registers, two data spaces and an executor.
// Assumes an APB master on pclk; one instruction is run per write to INSTR.
// How it works
// [RULE_01] Accumulator takes source-mode results
// [RULE_02] Index register supplies indexed offsets
// [RULE_03] Stack pointer holds top of stack
// [RULE_04] Program counter high byte register
// [RULE_05] Program counter low byte register
// [RULE_06] Immediate operand goes to A/F/SP/X
// [RULE_07] Every instruction is two bytes long
// [RULE_08] AND immediate into flag register
// [RULE_09] Direct source read from selected space
// [RULE_10] Direct/indexed arithmetic uses destination register
// [RULE_11] Indexed address is operand plus index
// [RULE_12] Destination direct writes A/X to memory
// [RULE_13] Destination arithmetic reads target first
// [RULE_14] Flags readable only at fixed address
// [RULE_15] Flags change only by OR/AND immediate
// [RULE_16] Indexed sum wraps modulo 256
`timescale 1ns/1ps
`default_nettype none
module coa_core import coa_pkg::*; #(
  parameter int DEPTH = 256
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // Elaboration check: index sums are eight bits, so a space holds at most 256 bytes
  if (DEPTH < 1 || DEPTH > 256) begin : g_depth_chk
    $error("coa_core: DEPTH must be 1..256");
  end

  typedef enum logic [1:0] {
    COA_S_IDLE = 2'h0,
    COA_S_EXEC = 2'h1
  } coa_state_t;

  logic [7:0] acc_r;
  logic [7:0] idx_r;
  logic [7:0] sp_r;
  logic [7:0] flag_r;
  logic [7:0] pch_r;
  logic [7:0] pcl_r;
  logic [16:0] instr_r;
  logic [7:0] ram_r [DEPTH];
  logic [7:0] regsp_r [DEPTH];
  coa_state_t state_r;
  logic bad_r;

  // Decoded instruction fields
  logic [7:0] opnd;
  coa_op_t op;
  coa_mode_t mode;
  coa_reg_t dreg;
  logic space;
  assign opnd = instr_r[COA_F_OPND +: 8];
  assign op = coa_op_t'(instr_r[COA_F_OP +: 3]);
  assign mode = coa_mode_t'(instr_r[COA_F_MODE +: 3]);
  assign dreg = coa_reg_t'(instr_r[COA_F_REG +: 2]);
  assign space = instr_r[COA_F_SPACE];

  // Shared ALU: a is the second source, b the first
  function automatic logic [7:0] coa_alu(input coa_op_t o, input logic [7:0] a, input logic [7:0] b);
    case (o)
      COA_OP_MOV: coa_alu = b;
      COA_OP_ADD: coa_alu = 8'(a + b);
      COA_OP_SUB: coa_alu = 8'(a - b);
      COA_OP_AND: coa_alu = a & b;
      COA_OP_OR: coa_alu = a | b;
      COA_OP_XOR: coa_alu = a ^ b;
      default: coa_alu = b;
    endcase
  endfunction : coa_alu

  // Memory fetch from either space; out-of-depth addresses read zero
  function automatic logic [7:0] coa_rd(input logic sp, input logic [7:0] a, input logic [7:0] ram_v,
                                        input logic [7:0] reg_v);
    if (32'(a) >= DEPTH) begin
      coa_rd = 8'h00;
    end else begin
      coa_rd = sp ? reg_v : ram_v;
    end
  endfunction : coa_rd

  // Effective address, index sum truncated to eight bits
  logic [7:0] eaddr;
  logic [7:0] mem_val;
  logic [7:0] dreg_val;
  logic [7:0] src_val;
  logic [7:0] result;
  logic flag_hit;
  always_comb begin
    eaddr = (mode == COA_M_SRC_IDX) ? 8'(opnd + idx_r) : opnd; // RULE_11 RULE_16
    flag_hit = space && (eaddr == COA_FLAG_ADDR); // RULE_14
    dreg_val = (dreg == COA_R_IDX) ? idx_r : acc_r; // RULE_10
    mem_val = flag_hit ? flag_r : coa_rd(space, eaddr, ram_r[eaddr], regsp_r[eaddr]); // RULE_09
    src_val = 8'h00;
    result = 8'h00;
    case (mode)
      COA_M_SRC_IMM: begin
        src_val = opnd; // RULE_06
        case (dreg)
          COA_R_FLAG: result = coa_alu(op, flag_r, src_val); // RULE_08
          COA_R_SP: result = coa_alu(op, sp_r, src_val);
          COA_R_IDX: result = coa_alu(op, idx_r, src_val);
          default: result = coa_alu(op, acc_r, src_val);
        endcase
      end
      COA_M_SRC_DIR, COA_M_SRC_IDX: begin
        src_val = mem_val;
        result = coa_alu(op, dreg_val, src_val); // RULE_10
      end
      COA_M_DST_DIR: begin
        src_val = dreg_val; // RULE_12
        result = coa_alu(op, mem_val, src_val); // RULE_13
      end
      default: result = 8'h00;
    endcase
  end

  // APB decode; zero wait states
  logic acc_en;
  logic wr_en;
  logic [11:0] waddr;
  logic mem_win;
  assign acc_en = psel && penable;
  assign wr_en = acc_en && pwrite;
  assign waddr = paddr - 12'(COA_OFF_MEM);
  // Bit 10 of the window offset picks the space; only DEPTH words of each exist
  assign mem_win = (paddr >= 12'(COA_OFF_MEM)) && (waddr[11] == 1'b0) && (32'(waddr[9:2]) < DEPTH) &&
                   (paddr[1:0] == 2'h0);

  function automatic logic coa_reg_hit(input logic [11:0] a);
    coa_reg_hit = (a[11:8] == 4'h0) && (a[7:0] <= COA_OFF_FLAG) && (a[1:0] == 2'h0);
  endfunction : coa_reg_hit

  logic exec;
  assign exec = (state_r == COA_S_EXEC);

  // Sequencer: INSTR write arms one execute cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= COA_S_IDLE;
      instr_r <= 17'h00000;
    end else begin
      case (state_r)
        COA_S_IDLE: begin
          if (wr_en && paddr == 12'(COA_OFF_INSTR)) begin
            instr_r <= pwdata[16:0];
            state_r <= COA_S_EXEC;
          end
        end
        COA_S_EXEC: state_r <= COA_S_IDLE;
        default: state_r <= COA_S_IDLE;
      endcase
    end
  end

  // Illegal encoding: unknown mode or op, non-immediate flag/SP destination, or flag op other than AND/OR
  logic bad_instr;
  assign bad_instr = (mode > COA_M_DST_DIR) || (op > COA_OP_XOR) ||
                     (mode != COA_M_SRC_IMM && (dreg == COA_R_FLAG || dreg == COA_R_SP)) ||
                     (mode == COA_M_SRC_IMM && dreg == COA_R_FLAG && op != COA_OP_AND && op != COA_OP_OR);

  // Core registers; software writes lose to a same-cycle execute
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= COA_RST_BYTE;
      idx_r <= COA_RST_BYTE;
      sp_r <= COA_RST_BYTE;
      flag_r <= COA_RST_FLAG;
      pch_r <= COA_RST_BYTE;
      pcl_r <= COA_RST_BYTE;
      bad_r <= 1'b0;
    end else if (exec) begin
      bad_r <= bad_instr;
      {pch_r, pcl_r} <= {pch_r, pcl_r} + COA_INSTR_LEN; // RULE_04 RULE_05 RULE_07
      if (!bad_instr && mode != COA_M_DST_DIR) begin
        case (dreg)
          COA_R_ACC: acc_r <= result; // RULE_01
          COA_R_FLAG: flag_r <= result; // RULE_08 RULE_15
          COA_R_SP: sp_r <= result; // RULE_03
          COA_R_IDX: idx_r <= result; // RULE_02
          default: acc_r <= acc_r;
        endcase
      end
    end else if (wr_en) begin
      case (paddr)
        12'(COA_OFF_ACC): acc_r <= pwdata[7:0];
        12'(COA_OFF_IDX): idx_r <= pwdata[7:0];
        12'(COA_OFF_SP): sp_r <= pwdata[7:0];
        12'(COA_OFF_PCH): pch_r <= pwdata[7:0];
        12'(COA_OFF_PCL): pcl_r <= pwdata[7:0];
        default: bad_r <= bad_r;
      endcase
    end
  end

  // Data spaces; executed stores skip the flag address in register space, APB window writes to it still land
  logic st_en;
  logic mem_wr;
  logic [8:0] mw_idx;
  assign st_en = exec && !bad_instr && mode == COA_M_DST_DIR && !flag_hit; // RULE_12 RULE_14
  assign mem_wr = wr_en && mem_win && !exec;
  assign mw_idx = waddr[10:2];
  always_ff @(posedge pclk) begin
    if (st_en && 32'(eaddr) < DEPTH) begin
      if (space) begin
        regsp_r[eaddr] <= result;
      end else begin
        ram_r[eaddr] <= result;
      end
    end else if (mem_wr) begin
      if (mw_idx[8]) begin
        regsp_r[mw_idx[7:0]] <= pwdata[7:0];
      end else begin
        ram_r[mw_idx[7:0]] <= pwdata[7:0];
      end
    end
  end

  // Read data and response, registered for flop-driven outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(coa_reg_hit(paddr) || mem_win);
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          12'(COA_OFF_ACC): prdata <= {24'h000000, acc_r};
          12'(COA_OFF_IDX): prdata <= {24'h000000, idx_r};
          12'(COA_OFF_SP): prdata <= {24'h000000, sp_r};
          12'(COA_OFF_PCH): prdata <= {24'h000000, pch_r};
          12'(COA_OFF_PCL): prdata <= {24'h000000, pcl_r};
          12'(COA_OFF_INSTR): prdata <= {15'h0000, instr_r};
          12'(COA_OFF_STAT): prdata <= {30'h00000000, bad_r, exec};
          default: begin
            if (mem_win) begin
              prdata <= {24'h000000, waddr[10] ? regsp_r[waddr[9:2]] : ram_r[waddr[9:2]]};
            end
          end
        endcase
      end
    end
  end

  // Assertions: program counter steps only on an executed instruction
  pc_step_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    exec |=> {pch_r, pcl_r} == $past({pch_r, pcl_r}) + COA_INSTR_LEN)
    else $error("pc did not advance by two");
  pc_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04 RULE_05
    !exec && !(wr_en && (paddr == 12'(COA_OFF_PCH) || paddr == 12'(COA_OFF_PCL)))
    |=> {pch_r, pcl_r} == $past({pch_r, pcl_r}))
    else $error("pc moved without cause");

  // Core register loads
  acc_load_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    exec && !bad_instr && mode != COA_M_DST_DIR && dreg == COA_R_ACC |=> acc_r == $past(result))
    else $error("accumulator missed result");
  idx_src_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    exec && !bad_instr && mode == COA_M_SRC_IMM && op == COA_OP_MOV && dreg == COA_R_IDX
    |=> idx_r == $past(opnd))
    else $error("immediate move to index wrong");
  imm_src_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03 RULE_06
    exec && !bad_instr && mode == COA_M_SRC_IMM && op == COA_OP_MOV && dreg == COA_R_SP
    |=> sp_r == $past(opnd))
    else $error("immediate move to stack pointer wrong");
  idx_load_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09 RULE_10
    exec && !bad_instr && mode == COA_M_SRC_DIR && dreg == COA_R_IDX && op == COA_OP_ADD
    |=> idx_r == 8'($past(idx_r) + $past(mem_val)))
    else $error("direct add into index wrong");
  // Illegal encodings leave A, X, SP and flags alone; the program counter still steps
  bad_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
    exec && bad_instr |=> acc_r == $past(acc_r) && idx_r == $past(idx_r) && sp_r == $past(sp_r) &&
      flag_r == $past(flag_r))
    else $error("illegal instruction changed a register");

  // Address forming and memory results
  idx_wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11 RULE_16
    mode == COA_M_SRC_IDX |-> 9'(eaddr) == ((9'(opnd) + 9'(idx_r)) & 9'h0ff))
    else $error("indexed address wrong");
  dst_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
    exec && mode == COA_M_DST_DIR |=> acc_r == $past(acc_r) && idx_r == $past(idx_r))
    else $error("destination mode changed a register");
  dst_store_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
    exec && !bad_instr && mode == COA_M_DST_DIR && op == COA_OP_MOV && 32'(eaddr) < DEPTH &&
    !(space && opnd == COA_FLAG_ADDR)
    |=> ($past(space) ? regsp_r[$past(eaddr)] : ram_r[$past(eaddr)]) ==
        ($past(dreg) == COA_R_IDX ? $past(idx_r) : $past(acc_r)))
    else $error("destination move stored wrong value");
  dst_rmw_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
    exec && !bad_instr && mode == COA_M_DST_DIR && !space && op == COA_OP_ADD && 32'(eaddr) < DEPTH
    |=> ram_r[$past(eaddr)] == 8'($past(mem_val) + $past(dreg_val)))
    else $error("destination add wrong");

  // Flag register: changed only by OR/AND immediate, read only at its fixed address
  flag_only_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
    flag_r != $past(flag_r) |-> $past(exec && mode == COA_M_SRC_IMM && dreg == COA_R_FLAG))
    else $error("flag changed outside immediate op");
  flag_and_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
    exec && !bad_instr && mode == COA_M_SRC_IMM && dreg == COA_R_FLAG && op == COA_OP_AND
    |=> flag_r == ($past(flag_r) & $past(opnd)))
    else $error("flag and wrong");
  flag_or_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
    exec && !bad_instr && mode == COA_M_SRC_IMM && dreg == COA_R_FLAG && op == COA_OP_OR
    |=> flag_r == ($past(flag_r) | $past(opnd)))
    else $error("flag or wrong");
  flag_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
    exec && !bad_instr && mode == COA_M_SRC_DIR && space && opnd == COA_FLAG_ADDR && op == COA_OP_MOV &&
    dreg == COA_R_ACC |=> acc_r == $past(flag_r))
    else $error("flag not seen at fixed address");

  // Bus response: one access cycle, error only with ready, data zero when idle; execute lasts one cycle
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("no ready after setup");
  err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error response without ready");
  rd_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h00000000)
    else $error("read data not zero outside access");
  exec_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec |=> !exec)
    else $error("execute lasted more than one cycle");

  // Coverage of the main scenarios
  exec_c: cover property (@(posedge pclk) disable iff (!presetn) exec && mode == COA_M_SRC_IDX);
  dst_c: cover property (@(posedge pclk) disable iff (!presetn) exec && mode == COA_M_DST_DIR && op == COA_OP_ADD);
  flag_c: cover property (@(posedge pclk) disable iff (!presetn) exec && dreg == COA_R_FLAG && mode == COA_M_SRC_IMM);
  bad_c: cover property (@(posedge pclk) disable iff (!presetn) exec && bad_instr);
  wrap_c: cover property (@(posedge pclk) disable iff (!presetn)
    exec && mode == COA_M_SRC_IDX && (9'(opnd) + 9'(idx_r)) > 9'h0ff);
endmodule : coa_core
`default_nettype wire

// ==== hdl/coa_pkg.sv ====
// Package for the operand addressing core: register map, mode and op codes.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package coa_pkg;
  // APB byte offsets of the software-visible registers
  localparam logic [7:0] COA_OFF_ACC = 8'h00;
  localparam logic [7:0] COA_OFF_IDX = 8'h04;
  localparam logic [7:0] COA_OFF_SP = 8'h08;
  localparam logic [7:0] COA_OFF_PCH = 8'h0c;
  localparam logic [7:0] COA_OFF_PCL = 8'h10;
  localparam logic [7:0] COA_OFF_INSTR = 8'h14;
  localparam logic [7:0] COA_OFF_STAT = 8'h18;
  localparam logic [7:0] COA_OFF_FLAG = 8'h1c;
  localparam logic [7:0] COA_OFF_MEM = 8'h20;
  // Reset values
  localparam logic [7:0] COA_RST_BYTE = 8'h00;
  localparam logic [7:0] COA_RST_FLAG = 8'h02;
  // Fixed register-space address of the flag register
  localparam logic [7:0] COA_FLAG_ADDR = 8'hf7;
  // Instruction word fields: [7:0] operand, [10:8] op, [13:11] mode, [15:14] reg, [16] register space
  localparam int COA_F_OPND = 0;
  localparam int COA_F_OP = 8;
  localparam int COA_F_MODE = 11;
  localparam int COA_F_REG = 14;
  localparam int COA_F_SPACE = 16;
  // Length in bytes of every supported instruction
  localparam logic [15:0] COA_INSTR_LEN = 16'h0002;
  typedef enum logic [2:0] {
    COA_M_SRC_IMM = 3'h0,
    COA_M_SRC_DIR = 3'h1,
    COA_M_SRC_IDX = 3'h2,
    COA_M_DST_DIR = 3'h3
  } coa_mode_t;
  typedef enum logic [2:0] {
    COA_OP_MOV = 3'h0,
    COA_OP_ADD = 3'h1,
    COA_OP_SUB = 3'h2,
    COA_OP_AND = 3'h3,
    COA_OP_OR = 3'h4,
    COA_OP_XOR = 3'h5
  } coa_op_t;
  typedef enum logic [1:0] {
    COA_R_ACC = 2'h0,
    COA_R_FLAG = 2'h1,
    COA_R_SP = 2'h2,
    COA_R_IDX = 2'h3
  } coa_reg_t;
endpackage : coa_pkg

// ==== test/test_cpu_operand_addressing.sv ====
// Testbench for the operand addressing core: APB register access and the four operand modes.
// Assumes coa_pkg and coa_core are compiled first; single pclk domain, bench drives APB itself.
`timescale 1ns/1ps
`default_nettype none
module test_cpu_operand_addressing import coa_pkg::*; ();
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int num_errors = 0;
  int num_checks = 0;
  logic [15:0] pc_e;
  logic [7:0] acc_e, idx_e, m, v;
  logic [7:0] vals [5];
  logic [7:0] offs [5] = '{COA_OFF_ACC, COA_OFF_IDX, COA_OFF_SP, COA_OFF_PCH, COA_OFF_PCL};
  logic [31:0] q;
  logic e;
  coa_op_t o;
  coa_reg_t g;

  coa_core #(.DEPTH(256)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // 10 MHz clock
  initial begin
    forever #50 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
    num_checks++;
    if (s !== ex) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, s);
    end
  endtask : chk

  // One APB transfer; the trailing idle edge also covers the execute cycle after an INSTR write
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rq,
    output logic re);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      $display("[ERR] pready expected 1 seen %b", pready);
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic re;
    apb(1'b1, a, d, rq, re);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] ex, input string nm);
    logic [31:0] rq;
    logic re;
    apb(1'b0, a, 32'h00000000, rq, re);
    chk(nm, {24'h000000, ex}, rq);
    chk("pslverr", 32'h00000000, {31'h00000000, re});
  endtask : rd

  // Issue one instruction; every instruction advances the program counter by two
  task automatic run(input coa_mode_t md, input coa_op_t op, input coa_reg_t rg, input logic sp,
    input logic [7:0] opnd);
    wr({4'h0, COA_OFF_INSTR}, {15'h0000, sp, rg, md, op, opnd});
    pc_e = pc_e + 16'h0002;
  endtask : run

  function automatic logic [11:0] maddr(input logic sp, input logic [7:0] i);
    return 12'h020 + {1'b0, sp, i, 2'b00};
  endfunction : maddr

  // Reference ALU; SUB is destination minus source
  function automatic logic [7:0] alu(input coa_op_t op, input logic [7:0] a, input logic [7:0] b);
    case (op)
      COA_OP_ADD: return a + b;
      COA_OP_SUB: return a - b;
      COA_OP_AND: return a & b;
      COA_OP_OR: return a | b;
      COA_OP_XOR: return a ^ b;
      default: return b;
    endcase
  endfunction : alu

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    print_verdict();
  end

  initial begin
    q = $urandom(32'hd445);
    pc_e = 16'h0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) rd({4'h0, offs[i]}, 8'h00, "reset value");
    rd({4'h0, COA_OFF_FLAG}, 8'h00, "flag window");
    run(COA_M_SRC_DIR, COA_OP_MOV, COA_R_ACC, 1'b1, COA_FLAG_ADDR);
    rd({4'h0, COA_OFF_ACC}, COA_RST_FLAG, "flag via 0xf7");
    apb(1'b0, 12'h900, 32'h00000000, q, e);
    chk("unmapped err", 32'h00000001, {31'h00000000, e});
    // Random register values, read back; PC bytes taken from what was written
    for (int i = 0; i < 5; i++) begin
      vals[i] = 8'($urandom);
      wr({4'h0, offs[i]}, {24'h000000, vals[i]});
      rd({4'h0, offs[i]}, vals[i], "reg rw");
    end
    acc_e = vals[0];
    idx_e = vals[1];
    pc_e = {vals[3], vals[4]};
    // Flag set by OR, cleared by AND, then seen only through register space
    run(COA_M_SRC_IMM, COA_OP_OR, COA_R_FLAG, 1'b0, 8'h81);
    run(COA_M_SRC_IMM, COA_OP_AND, COA_R_FLAG, 1'b0, 8'hf6);
    run(COA_M_SRC_IMM, COA_OP_MOV, COA_R_SP, 1'b0, 8'h5a);
    rd({4'h0, COA_OFF_SP}, 8'h5a, "sp imm");
    // Random immediate ALU traffic to accumulator and index
    for (int i = 0; i < 20; i++) begin
      o = coa_op_t'($urandom_range(0, 5));
      g = ($urandom_range(0, 1) == 1) ? COA_R_IDX : COA_R_ACC;
      v = 8'($urandom);
      run(COA_M_SRC_IMM, o, g, 1'b0, v);
      if (g == COA_R_ACC) acc_e = alu(o, acc_e, v);
      else idx_e = alu(o, idx_e, v);
      rd((g == COA_R_ACC) ? {4'h0, COA_OFF_ACC} : {4'h0, COA_OFF_IDX},
        (g == COA_R_ACC) ? acc_e : idx_e, "imm alu");
    end
    // A move into the flag is illegal: flag kept, status reports it, PC still steps
    run(COA_M_SRC_IMM, COA_OP_MOV, COA_R_FLAG, 1'b0, 8'hff);
    rd({4'h0, COA_OFF_STAT}, 8'h02, "illegal stat");
    run(COA_M_SRC_DIR, COA_OP_MOV, COA_R_IDX, 1'b1, COA_FLAG_ADDR);
    rd({4'h0, COA_OFF_IDX}, 8'h82, "flag or/and");
    idx_e = 8'h82;
    // Source direct from RAM with arithmetic, and from register space
    m = 8'($urandom);
    wr(maddr(1'b0, 8'h07), {24'h000000, m});
    run(COA_M_SRC_DIR, COA_OP_ADD, COA_R_ACC, 1'b0, 8'h07);
    acc_e = acc_e + m;
    rd({4'h0, COA_OFF_ACC}, acc_e, "src direct add");
    m = 8'($urandom);
    wr(maddr(1'b1, 8'h08), {24'h000000, m});
    run(COA_M_SRC_DIR, COA_OP_MOV, COA_R_IDX, 1'b1, 8'h08);
    idx_e = m;
    rd({4'h0, COA_OFF_IDX}, idx_e, "src direct reg");
    // Indexed address wraps past 0xff in RAM, then an unwrapped indexed read from register space
    run(COA_M_SRC_IMM, COA_OP_MOV, COA_R_IDX, 1'b0, 8'hf0);
    idx_e = 8'hf0;
    m = 8'($urandom);
    wr(maddr(1'b0, 8'h10), {24'h000000, m});
    run(COA_M_SRC_IDX, COA_OP_SUB, COA_R_ACC, 1'b0, 8'h20);
    acc_e = acc_e - m;
    rd({4'h0, COA_OFF_ACC}, acc_e, "indexed wrap sub");
    m = 8'($urandom);
    wr(maddr(1'b1, 8'hf3), {24'h000000, m});
    run(COA_M_SRC_IDX, COA_OP_MOV, COA_R_ACC, 1'b1, 8'h03);
    acc_e = m;
    rd({4'h0, COA_OFF_ACC}, acc_e, "indexed reg");
    // Destination direct: read-modify-write of memory, source left alone
    m = 8'($urandom);
    wr(maddr(1'b0, 8'h40), {24'h000000, m});
    run(COA_M_DST_DIR, COA_OP_ADD, COA_R_ACC, 1'b0, 8'h40);
    rd(maddr(1'b0, 8'h40), m + acc_e, "dst add");
    rd({4'h0, COA_OFF_ACC}, acc_e, "dst src kept");
    run(COA_M_DST_DIR, COA_OP_MOV, COA_R_IDX, 1'b1, 8'h08);
    rd(maddr(1'b1, 8'h08), idx_e, "dst reg mov");
    rd({4'h0, COA_OFF_PCH}, pc_e[15:8], "pc high");
    rd({4'h0, COA_OFF_PCL}, pc_e[7:0], "pc low");
    print_verdict();
  end
endmodule : test_cpu_operand_addressing
`default_nettype wire
